// file: common/sie_pkg.sv
// sie_pkg: constants and carrier types shared by the subtract execution block.
// assumes a 32-bit apb register bus and an 8-bit data path with a 12-bit data address.
package sie_pkg;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] SIE_OFS_INSTR = 8'h00;    // write issues one instruction
   localparam logic [7:0] SIE_OFS_WREG = 8'h04;     // working register
   localparam logic [7:0] SIE_OFS_BANK = 8'h08;     // bank select register
   localparam logic [7:0] SIE_OFS_INDEX = 8'h0c;    // base for indexed literal offset
   localparam logic [7:0] SIE_OFS_CFG = 8'h10;      // configuration
   localparam logic [7:0] SIE_OFS_STATUS = 8'h14;   // arithmetic flags, last issue state
   localparam logic [7:0] SIE_OFS_MADDR = 8'h18;    // data memory window address
   localparam logic [7:0] SIE_OFS_MDATA = 8'h1c;    // data memory window data

   // ==========================================================
   // field positions
   localparam int SIE_CFG_EXT_BIT = 0;        // extended instruction set enable
   localparam int SIE_ST_C_BIT = 0;           // carry, not-borrow
   localparam int SIE_ST_DC_BIT = 1;          // digit carry
   localparam int SIE_ST_Z_BIT = 2;           // zero
   localparam int SIE_ST_OV_BIT = 3;          // overflow
   localparam int SIE_ST_N_BIT = 4;           // negative
   localparam int SIE_ST_ILL_BIT = 8;         // last issued word was not a subtract
   localparam int SIE_INSTR_D_BIT = 9;        // destination select
   localparam int SIE_INSTR_A_BIT = 8;        // bank access select

   // ==========================================================
   // opcode patterns
   localparam logic [5:0] SIE_OP_FILE = 6'h17;      // top six bits 0101 11
   localparam logic [7:0] SIE_OP_LIT = 8'h08;       // top eight bits 0000 1000

   // ==========================================================
   // address map figures
   localparam logic [7:0] SIE_ACCESS_SPLIT = 8'h60;  // below: bank 0, else last bank
   localparam logic [7:0] SIE_INDEXED_MAX = 8'h5f;   // indexed mode when f at most this
   localparam logic [3:0] SIE_ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] SIE_ACCESS_HIGH_BANK = 4'hf;
   localparam int SIE_MEM_WORDS = 4096;

   // ==========================================================
   // reset values
   localparam logic [7:0] SIE_RST_WREG = 8'h00;
   localparam logic [3:0] SIE_RST_BANK = 4'h0;
   localparam logic [11:0] SIE_RST_INDEX = 12'h000;
   localparam logic [7:0] SIE_RST_BYTE = 8'h00;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } sie_flags_type;

   typedef struct packed {
      logic [7:0] diff;
      sie_flags_type flags;
   } sie_result_type;

   typedef struct packed {
      logic ext_on;        // extended set enabled
      logic bank_acc;      // 1: use bank select register
      logic [7:0] file;    // 8-bit file operand
   } sie_operand_type;

endpackage

// file: core/sie_addr.sv
// sie_addr: resolves an 8-bit file operand to a 12-bit data address.
// assumes bank and index values are stable flops of the caller.
`timescale 1ns/100ps
`default_nettype none
module sie_addr
   import sie_pkg::*;
(
   // operand and context
   input wire sie_operand_type operand,
   input wire logic [3:0] bank,
   input wire logic [11:0] index_base,
   // resolved address
   output logic [11:0] data_addr,
   output logic indexed
);

   // ==========================================================
   // address forms
   wire logic low_half = (operand.file < SIE_ACCESS_SPLIT);
   // indexed only with fixed access bank and extended set
   wire logic use_index = !operand.bank_acc && operand.ext_on && (operand.file <= SIE_INDEXED_MAX);
   wire logic [11:0] idx_addr = index_base + {4'h0, operand.file};   // wraps within data space
   wire logic [11:0] acc_addr = {(low_half ? SIE_ACCESS_LOW_BANK : SIE_ACCESS_HIGH_BANK), operand.file};
   wire logic [11:0] bsr_addr = {bank, operand.file};

   // ==========================================================
   // selection, indexed wins over plain access bank
   assign indexed = use_index;
   assign data_addr = use_index ? idx_addr : (operand.bank_acc ? bsr_addr : acc_addr);

endmodule // sie_addr
`default_nettype wire

// file: core/sie_alu.sv
// sie_alu: two's complement byte subtract with status flags.
// assumes operands come from flops on the same clock; purely combinational.
`timescale 1ns/100ps
`default_nettype none
module sie_alu
   import sie_pkg::*;
(
   // operands: minuend minus subtrahend
   input wire logic [7:0] minuend,
   input wire logic [7:0] subtrahend,
   // difference and flags
   output sie_result_type result
);

   // ==========================================================
   // adder form: a + ~b + 1, so carry out is not-borrow
   wire logic [8:0] full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
   wire logic [4:0] nib_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
   wire logic [7:0] diff = full_sum[7:0];
   // overflow only when signs differ and result sign leaves the minuend's
   wire logic ovf = (minuend[7] != subtrahend[7]) && (diff[7] != minuend[7]);

   // ==========================================================
   // pack result
   assign result.diff = diff;
   assign result.flags.n = diff[7];
   assign result.flags.ov = ovf;
   assign result.flags.z = (diff == 8'h00);
   assign result.flags.dc = nib_sum[4];
   assign result.flags.c = full_sum[8];

endmodule // sie_alu
`default_nettype wire

// file: core/sie_exec.sv
// sie_exec: subtract instruction execution unit with apb register access.
// assumes an apb master on pclk; every transfer completes with no wait state.
`timescale 1ns/100ps
`default_nettype none
module sie_exec
   import sie_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // ==========================================================
   // architectural state
   logic [7:0] working_reg;          // working register
   logic [3:0] bank_select_register; // bank for access bit 1
   logic [11:0] index_base;          // base for indexed literal offset
   logic ext_on;                     // extended instruction set enable
   sie_flags_type flags;             // n ov z dc c
   logic last_illegal;               // last issued word was not a subtract
   logic [11:0] mem_addr;            // software window address
   logic [7:0] data_mem [SIE_MEM_WORDS];  // data memory, all banks

   // ==========================================================
   // bus decode
   wire logic [7:0] ofs = paddr[7:0];
   wire logic aligned = (paddr[1:0] == 2'b00) && (paddr[31:8] == 24'h000000);
   wire logic hit_instr = aligned && (ofs == SIE_OFS_INSTR);
   wire logic hit_wreg = aligned && (ofs == SIE_OFS_WREG);
   wire logic hit_bank = aligned && (ofs == SIE_OFS_BANK);
   wire logic hit_index = aligned && (ofs == SIE_OFS_INDEX);
   wire logic hit_cfg = aligned && (ofs == SIE_OFS_CFG);
   wire logic hit_status = aligned && (ofs == SIE_OFS_STATUS);
   wire logic hit_maddr = aligned && (ofs == SIE_OFS_MADDR);
   wire logic hit_mdata = aligned && (ofs == SIE_OFS_MDATA);
   wire logic mapped = hit_instr | hit_wreg | hit_bank | hit_index | hit_cfg | hit_status | hit_maddr | hit_mdata;
   // access phase; slave never stalls
   wire logic access = psel && penable;
   wire logic setup = psel && !penable;
   // a write commits only in the access phase, once per transfer
   wire logic wr = access && pwrite && mapped;
   // low byte lane gates every byte-wide field
   wire logic lane0 = pstrb[0];
   wire logic lane1 = pstrb[1];

   // ==========================================================
   // instruction decode from the write data
   wire logic [15:0] iword = pwdata[15:0];
   wire logic is_file = (iword[15:10] == SIE_OP_FILE);
   wire logic is_lit = (iword[15:8] == SIE_OP_LIT);
   // issue needs both low lanes, a partial word cannot form an opcode
   wire logic issue = wr && hit_instr && lane0 && lane1;
   wire logic issue_file = issue && is_file;
   wire logic issue_lit = issue && is_lit;
   wire logic issue_ill = issue && !is_file && !is_lit;
   wire logic dest_mem = iword[SIE_INSTR_D_BIT];

   // ==========================================================
   // operand address resolution
   sie_operand_type operand;
   logic [11:0] file_addr;
   assign operand.ext_on = ext_on;
   assign operand.bank_acc = iword[SIE_INSTR_A_BIT];
   assign operand.file = iword[7:0];

   sie_addr u_addr (
      .operand(operand),
      .bank(bank_select_register),
      .index_base(index_base),
      .data_addr(file_addr),
      .indexed()
   );

   // ==========================================================
   // subtract: minuend is memory byte or literal, subtrahend is w
   wire logic [7:0] file_byte = data_mem[file_addr];
   wire logic [7:0] minuend = is_lit ? iword[7:0] : file_byte;
   sie_result_type result;

   sie_alu u_alu (
      .minuend(minuend),
      .subtrahend(working_reg),
      .result(result)
   );

   // ==========================================================
   // destination steering
   wire logic w_from_exec = issue_lit || (issue_file && !dest_mem);
   wire logic mem_from_exec = issue_file && dest_mem;
   wire logic w_from_bus = wr && hit_wreg && lane0;
   wire logic mem_from_bus = wr && hit_mdata && lane0;
   wire logic flags_from_exec = issue_file || issue_lit;
   wire logic flags_from_bus = wr && hit_status && lane0;

   // ==========================================================
   // read mux, captured in setup so prdata comes from a flop
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h00000000;
      unique case (1'b1)
         hit_wreg: next_rdata = {24'h000000, working_reg};
         hit_bank: next_rdata = {28'h0000000, bank_select_register};
         hit_index: next_rdata = {20'h00000, index_base};
         hit_cfg: next_rdata = {31'h00000000, ext_on};
         hit_status: next_rdata = {23'h000000, last_illegal, 3'b000, flags};
         hit_maddr: next_rdata = {20'h00000, mem_addr};
         hit_mdata: next_rdata = {24'h000000, data_mem[mem_addr]};
         default: next_rdata = 32'h00000000;  // instr and unmapped read zero
      endcase
   end

   // ==========================================================
   // apb answer: ready at once, error for unmapped addresses
   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   // read data latch; stable for the whole access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup) begin
         prdata <= pwrite ? 32'h00000000 : next_rdata;
      end
   end

   // ==========================================================
   // working register: exec and bus never collide, both come from one write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         working_reg <= SIE_RST_WREG;
      end else if (w_from_exec) begin
         working_reg <= result.diff;
      end else if (w_from_bus) begin
         working_reg <= pwdata[7:0];
      end
   end

   // ==========================================================
   // bank, index and configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_select_register <= SIE_RST_BANK;
         index_base <= SIE_RST_INDEX;
         ext_on <= 1'b0;
         mem_addr <= 12'h000;
      end else begin
         if (wr && hit_bank && lane0) begin
            bank_select_register <= pwdata[3:0];
         end
         if (wr && hit_index && lane0 && lane1) begin
            index_base <= pwdata[11:0];   // whole field only, avoids a torn base
         end
         if (wr && hit_cfg && lane0) begin
            ext_on <= pwdata[SIE_CFG_EXT_BIT];
         end
         if (wr && hit_maddr && lane0 && lane1) begin
            mem_addr <= pwdata[11:0];
         end
      end
   end

   // ==========================================================
   // status flags and issue state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= '0;
         last_illegal <= 1'b0;
      end else begin
         if (flags_from_exec) begin
            flags <= result.flags;
         end else if (flags_from_bus) begin
            flags <= pwdata[4:0];
         end
         if (issue) begin
            last_illegal <= issue_ill;   // unknown words change nothing else
         end
      end
   end

   // ==========================================================
   // data memory: no reset, cleared contents are up to software
   always_ff @(posedge pclk) begin
      if (mem_from_exec) begin
         data_mem[file_addr] <= result.diff;
      end else if (mem_from_bus) begin
         data_mem[mem_addr] <= pwdata[7:0];
      end
   end

endmodule // sie_exec
`default_nettype wire

// file: sim/sie_exec_properties.sv
// sie_exec_properties: port-level checks of the subtract execution unit.
// assumes it is bound to sie_exec and that the bench spaces transfers three cycles apart.
`timescale 1ns/100ps
`default_nettype none
module sie_exec_properties
   import sie_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // ==========================================================
   // helpers
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel && penable; // access phase
   wire bad_addr = (paddr[31:5] != 27'h0) || (paddr[1:0] != 2'h0); // outside the word map
   // one whole-word write or read completing at this edge
   sequence s_wr(logic [7:0] a);
      acc && pwrite && paddr == {24'h0, a} && pstrb == 4'hf;
   endsequence
   sequence s_rd(logic [7:0] a);
      acc && !pwrite && paddr == {24'h0, a};
   endsequence
   // file subtract issue with a given destination bit
   sequence s_file(logic d);
      s_wr(SIE_OFS_INSTR) ##0 (pwdata[15:10] == SIE_OP_FILE && pwdata[SIE_INSTR_D_BIT] == d);
   endsequence
   // ==========================================================
   // bus behaviour
   AST_READY_NO_WAIT: assert property (acc |-> pready) else $error("pready low in access");
   AST_ERR_ONLY_ACCESS: assert property (pslverr |-> acc) else $error("pslverr outside access");
   AST_ERR_DECODE: assert property (acc |-> pslverr == bad_addr) else $error("pslverr wrong for address");
   // read data must not move between access and the next setup
   AST_RDATA_HOLD: assert property (acc && !pwrite |=> $stable(prdata)) else $error("prdata moved");
   AST_INSTR_READS_ZERO: assert property (s_rd(SIE_OFS_INSTR) |-> prdata == 32'h0)
      else $error("issue register read not zero");
   // ==========================================================
   // arithmetic seen through back-to-back sequences
   AST_LIT_TO_W: assert property (
      s_wr(SIE_OFS_WREG) ##3 (s_wr(SIE_OFS_INSTR) ##0 pwdata[15:8] == SIE_OP_LIT) ##3 s_rd(SIE_OFS_WREG)
      |-> prdata == {24'h0, $past(pwdata[7:0], 3) - $past(pwdata[7:0], 6)}) else $error("literal result wrong");
   AST_FILE_TO_W: assert property (
      s_wr(SIE_OFS_MDATA) ##3 s_wr(SIE_OFS_WREG) ##3 s_file(1'b0) ##3 s_rd(SIE_OFS_WREG)
      |-> prdata == {24'h0, $past(pwdata[7:0], 9) - $past(pwdata[7:0], 6)}) else $error("file result to w wrong");
   AST_FILE_TO_MEM: assert property (
      s_wr(SIE_OFS_MDATA) ##3 s_wr(SIE_OFS_WREG) ##3 s_file(1'b1) ##3 s_rd(SIE_OFS_MDATA)
      |-> prdata == {24'h0, $past(pwdata[7:0], 9) - $past(pwdata[7:0], 6)}) else $error("file result to memory wrong");
endmodule // sie_exec_properties
bind sie_exec sie_exec_properties sie_exec_properties_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));
`default_nettype wire

// file: sim/testbench.sv
// testbench: self-checking bench for the subtract execution unit.
// assumes sie_exec answers apb on its own pace; reads are scored from a queue of notes.
`timescale 1ns/100ps
`default_nettype none
module testbench import sie_pkg::*;;
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
   $display("Error at %0t: got %h expected %h", $time, got, exp); end end
   // ==========================================================
   // signals
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata;
   logic [32:0] exp_now; // pslverr above read data
   logic [3:0] pstrb;
   logic [32:0] exp_q[$]; // notes of expected {pslverr, read data}, oldest first
   int miscompares, n_compared, cycles;
   logic ext, acc_bit, dst;
   logic [7:0] fsel;
   logic [3:0] bank;
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   sie_exec sie_exec_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // ==========================================================
   // scoring: each completed read takes the oldest note
   always @(posedge pclk) begin
      if (presetn && psel && penable && !pwrite && pready === 1'b1) begin
         if (exp_q.size() > 0) begin
            exp_now = exp_q.pop_front();
            `CHK({pslverr, prdata}, exp_now)
         end else begin
            // a read with no note is a bench fault, never a silent pass
            miscompares++;
            $display("Error at %0t: unnoted read got %h expected %h", $time, prdata, 32'h0);
         end
      end
   end
   // hang guard, well above the roughly thousand cycles the tests take
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         $display("Error at %0t: timeout got %h expected %h", $time, 32'h0, 32'h1);
         tally_and_finish;
      end
   end
   // ==========================================================
   // bus tasks: setup, access held until pready, then release
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      // unmapped or misaligned offsets must answer with pslverr
      exp_q.push_back({(a > SIE_OFS_MDATA) || (a[1:0] != 2'b00), e});
      xfer(1'b0, a, 32'h0);
   endtask
   // expected status word for a minus b
   function automatic logic [31:0] status_of(input logic [7:0] a, b, input logic ill);
      logic [7:0] r;
      r = a - b;
      return {23'h0, ill, 3'h0, r[7], (a[7] != b[7]) && (r[7] != a[7]), r == 8'h0, a[3:0] >= b[3:0], a >= b};
   endfunction
   // expected data address of a file operand
   function automatic logic [11:0] resolve(input logic [3:0] bk, input logic ext_on, a, input logic [7:0] f);
      if (a) return {bk, f};
      if (ext_on && f <= 8'h5f) return 12'hfc0 + {4'h0, f};
      return {(f < 8'h60) ? 4'h0 : 4'hf, f};
   endfunction
   task lit(input logic [7:0] w, k);
      xfer(1'b1, SIE_OFS_WREG, {24'h0, w});
      xfer(1'b1, SIE_OFS_INSTR, {16'h0, SIE_OP_LIT, k});
      rd(SIE_OFS_WREG, {24'h0, k - w});
      rd(SIE_OFS_STATUS, status_of(k, w, 1'b0));
   endtask
   task file_op(input logic [11:0] ad, input logic [7:0] f, input logic a, d, input logic [7:0] m, w);
      xfer(1'b1, SIE_OFS_MADDR, {20'h0, ad});
      xfer(1'b1, SIE_OFS_MDATA, {24'h0, m});
      xfer(1'b1, SIE_OFS_WREG, {24'h0, w});
      xfer(1'b1, SIE_OFS_INSTR, {16'h0, SIE_OP_FILE, d, a, f});
      rd(d ? SIE_OFS_MDATA : SIE_OFS_WREG, {24'h0, m - w});
      rd(d ? SIE_OFS_WREG : SIE_OFS_MDATA, {24'h0, d ? w : m});
      rd(SIE_OFS_STATUS, status_of(m, w, 1'b0));
   endtask
   task tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      pstrb = 4'hf;
      {miscompares, n_compared, cycles} = '0;
      void'($urandom(33849));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      // every register but the data window clears on reset, issue register reads zero
      for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'h0);
      $display("test reset_values done");
      // boundary and sign cases, then random pairs
      lit(8'h01, 8'h02);
      lit(8'h03, 8'h02);
      lit(8'h01, 8'h80);
      repeat (12) lit(8'($urandom), 8'($urandom));
      $display("test literal_subtract done");
      // every mode of access bit, extension and destination, at the 0x5f/0x60 edge
      xfer(1'b1, SIE_OFS_INDEX, 32'h0fc0);
      for (int i = 0; i < 24; i++) begin
         {ext, acc_bit, dst} = 3'(i);
         bank = (i < 16) ? 4'h5 : 4'($urandom);
         fsel = (i < 8) ? 8'h5f : (i < 16) ? 8'h60 : 8'($urandom);
         xfer(1'b1, SIE_OFS_BANK, {28'h0, bank});
         xfer(1'b1, SIE_OFS_CFG, {31'h0, ext});
         file_op(resolve(bank, ext, acc_bit, fsel), fsel, acc_bit, dst, 8'($urandom), 8'($urandom));
      end
      $display("test file_subtract done");
      // refused addresses, a foreign word marks status, a valid issue clears it
      rd(8'h20, 32'h0);
      rd(8'h06, 32'h0);
      lit(8'h05, 8'h03);
      xfer(1'b1, SIE_OFS_INSTR, 32'h0000ffff);
      rd(SIE_OFS_STATUS, status_of(8'h03, 8'h05, 1'b1));
      lit(8'h02, 8'h02);
      // writes without the needed byte lanes change nothing
      pstrb <= 4'h0;
      xfer(1'b1, SIE_OFS_WREG, 32'h000000aa);
      pstrb <= 4'h1;
      xfer(1'b1, SIE_OFS_INSTR, {16'h0, SIE_OP_LIT, 8'h44});
      pstrb <= 4'hf;
      rd(SIE_OFS_WREG, 32'h0);
      rd(SIE_OFS_STATUS, status_of(8'h02, 8'h02, 1'b0));
      $display("test refused_and_foreign done");
      repeat (4) @(posedge pclk);
      tally_and_finish;
   end
endmodule // testbench
`default_nettype wire
